// [hw/bmie_map.svh]
`ifndef BMIE_MAP_SVH
`define BMIE_MAP_SVH

// register offsets on the plain register port (byte addresses)
`define BMIE_REG_STATUS 8'h00
`define BMIE_REG_MASK 8'h04
`define BMIE_REG_STATE 8'h08
`define BMIE_REG_ACC 8'h0c
`define BMIE_REG_PC 8'h10
`define BMIE_REG_TABLE_HIGH 8'h14

// event bit positions, shared by status and mask
`define BMIE_EV_SKIP 0
`define BMIE_EV_HALT 1
`define BMIE_EV_WATCHDOG 2
`define BMIE_EV_TIMEOUT 3
`define BMIE_EV_W 4

// state register fields
`define BMIE_ST_POWER_DOWN 0
`define BMIE_ST_TIMEOUT 1
`define BMIE_ST_HALTED 2
`define BMIE_ST_SP_LSB 8

// reset values
`define BMIE_RST_ACC 8'h00
`define BMIE_RST_MASK 4'h0

// data memory address that aliases the low program counter byte
`define BMIE_PC_LOW_ADDR 8'h06

// system clocks per instruction cycle
`define BMIE_CLKS_PER_CYCLE 4

`endif

// [hw/bmie_pkg.sv]
package bmie_pkg;

   typedef enum logic [4:0] {
      no_operation = 5'h00,
      jump_op = 5'h01,
      call_op = 5'h02,
      subroutine_return_op = 5'h03,
      return_imm_op = 5'h04,
      interrupt_return_op = 5'h05,
      skip_zero_op = 5'h06,
      skip_zero_copy_op = 5'h07,
      skip_bit_clear_op = 5'h08,
      skip_bit_set_op = 5'h09,
      inc_skip_op = 5'h0a,
      dec_skip_op = 5'h0b,
      inc_skip_to_acc_op = 5'h0c,
      dec_skip_to_acc_op = 5'h0d,
      table_read_current_page = 5'h0e,
      table_read_last_page = 5'h0f,
      clear_mem_op = 5'h10,
      set_mem_op = 5'h11,
      watchdog_clear_op = 5'h12,
      watchdog_preclear_first = 5'h13,
      watchdog_preclear_second = 5'h14,
      nibble_exchange_op = 5'h15,
      nibble_exchange_to_acc_op = 5'h16,
      halt_op = 5'h17
   } bmie_op_t;

   // gray along idle -> exec -> wait -> halt -> idle; the direct wait -> idle step flips both bits
   typedef enum logic [1:0] {
      bmie_idle = 2'b00,
      bmie_exec = 2'b01,
      bmie_wait = 2'b11,
      bmie_halt = 2'b10
   } bmie_state_t;

endpackage

// [hw/bmie_seq_if.sv]
`timescale 1ns/1ps
interface bmie_seq_if;
   logic start;
   logic [1:0] ncyc;
   logic done;
   modport ctl (output start, output ncyc, input done);
   modport seq (input start, input ncyc, output done);
endinterface

// [hw/bmie_cycle_seq.sv]
`timescale 1ns/1ps
`include "bmie_map.svh"
module bmie_cycle_seq
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   bmie_seq_if.seq sq
);
   logic busy;
   logic [3:0] remaining;

   // start arrives one clock after acceptance, so the load is short by two
   assign sq.done = busy && (remaining == 4'h1);

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy <= 1'b0;
         remaining <= 4'h0;
      end
      else if (clk_en)
      begin
         if (sq.start)
         begin
            busy <= 1'b1;
            remaining <= 4'(sq.ncyc * `BMIE_CLKS_PER_CYCLE - 2); // see RQ7
         end
         else if (sq.done)
            busy <= 1'b0;
         else if (busy)
            remaining <= remaining - 4'h1;
      end
   end
endmodule

// [hw/bmie_core.sv]
`timescale 1ns/1ps
`include "bmie_map.svh"
// Function
// RQ1: jump, call, returns take two cycles, touch no flags.
// RQ2: zero-test skip skips on zero byte; copy form also loads accumulator.
// RQ3: bit-test skip tests bit 0..7; one skips on clear, other on set.
// RQ4: increment/decrement skip write back, skip on zero, both penalties apply.
// RQ5: accumulator forms put result in accumulator, memory untouched, skip on zero.
// RQ6: a taken skip adds one instruction cycle.
// RQ7: writing the low program counter byte adds a cycle; cycle is four clocks.
// RQ8: current-page table read: low byte to memory, high bits to latch.
// RQ9: last-page table read fetches from final page, two cycles.
// RQ10: nibble swap in place; accumulator form writes accumulator, one cycle.
// RQ11: watchdog clear resets counter and clears timeout and power-down flags.
// RQ12: pre-clear pair clears only when both executed; lone one changes nothing.
// RQ13: halt enters power-down in one cycle and updates both flags.
// RQ14: no-operation takes one cycle and only advances the program counter.
// RQ15: halt stops clock, keeps state, clears watchdog, sets power-down, clears timeout.
// RQ16: call pushes next address before loading the target.
// RQ17: set-memory writes all ones, clear-memory all zeros, no flags.
// RQ18: a skipped instruction is dropped and the added cycle acts as no-operation.
module bmie_core
   import bmie_pkg::*;
#(
   parameter int PC_W = 12,
   parameter int PM_W = 15,
   parameter int STACK_DEPTH = 8
)
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic instr_valid,
   output logic instr_ready,
   input wire bmie_op_t instr_op,
   input wire logic [7:0] instr_addr,
   input wire logic [2:0] instr_bit,
   input wire logic [7:0] instr_imm,
   input wire logic [PC_W-1:0] instr_target,
   input wire logic [7:0] tbl_ptr,
   output logic instr_done,
   output logic skip_taken,
   output logic [7:0] dm_addr,
   input wire logic [7:0] dm_rdata,
   output logic dm_we,
   output logic [7:0] dm_wdata,
   output logic [PC_W-1:0] pm_addr,
   input wire logic [PM_W-1:0] pm_rdata,
   output logic [PC_W-1:0] pc,
   output logic [7:0] accumulator,
   output logic [PM_W-9:0] table_high_latch,
   output logic timeout_flag,
   output logic power_down_flag,
   output logic watchdog_reset,
   output logic sys_clk_stop,
   output logic int_return,
   input wire logic watchdog_timeout,
   input wire logic wake,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq
);
   localparam int SP_W = $clog2(STACK_DEPTH + 1);

   // a single-entry stack would leave the stack index with no bits at all
   if (PC_W < 9 || PC_W > 16 || PM_W < 9 || PM_W > 16 || STACK_DEPTH < 2)
   begin
      $error("bmie_core: unsupported parameter values");
   end

   function automatic logic [7:0] swap_nib(input logic [7:0] v);
      return {v[3:0], v[7:4]};
   endfunction

   function automatic logic is_zero(input logic [7:0] v);
      return v == 8'h00;
   endfunction

   logic rst_q1;
   logic rst_n;
   bmie_state_t state;
   bmie_op_t op_q;
   logic [2:0] bit_q;
   logic [7:0] imm_q;
   logic [PC_W-1:0] target_q;
   logic [PC_W-1:0] stack [STACK_DEPTH];
   logic [SP_W-1:0] sp;
   logic pre1_seen;
   logic pre2_seen;
   logic [`BMIE_EV_W-1:0] ev_status;
   logic [`BMIE_EV_W-1:0] ev_mask;
   logic halt_pending;

   // reset released through two flops; the first is read only by the second
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_q1 <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_q1 <= 1'b1;
         rst_n <= rst_q1;
      end
   end

   bmie_seq_if seq_bus();
   bmie_cycle_seq u_seq
   (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .sq(seq_bus)
   );

   // decode of the latched instruction against the data it reads
   logic commit;
   logic accept;
   logic sel_bit;
   logic [7:0] inc_val;
   logic [7:0] dec_val;
   logic [PM_W-9:0] pm_hi;
   logic wr_mem;
   logic wr_acc;
   logic skip;
   logic two_base;
   logic [7:0] res;
   logic pc_low_hit;
   logic [1:0] ncyc;
   logic [PC_W-1:0] pc_next_seq;
   logic [PC_W-1:0] stack_top;
   logic [SP_W-1:0] sp_dec;
   logic pre_pair;
   logic wd_clear;
   logic [PC_W-1:0] next_pc;

   assign accept = instr_valid && instr_ready && clk_en;
   assign commit = state == bmie_exec;
   assign sel_bit = dm_rdata[bit_q];
   assign inc_val = dm_rdata + 8'h01;
   assign dec_val = dm_rdata - 8'h01;
   assign pm_hi = pm_rdata[PM_W-1:8];
   assign instr_ready = state == bmie_idle;
   assign instr_done = seq_bus.done;
   assign sys_clk_stop = state == bmie_halt; // see RQ15

   always_comb
   begin
      wr_mem = 1'b0;
      wr_acc = 1'b0;
      skip = 1'b0;
      two_base = 1'b0;
      res = dm_rdata;
      unique case (op_q)
         jump_op, call_op, subroutine_return_op, interrupt_return_op:
            two_base = 1'b1; // see RQ1
         return_imm_op:
         begin
            two_base = 1'b1;
            wr_acc = 1'b1;
            res = imm_q;
         end
         skip_zero_op:
            skip = is_zero(dm_rdata); // see RQ2
         skip_zero_copy_op:
         begin
            skip = is_zero(dm_rdata);
            wr_acc = 1'b1;
         end
         skip_bit_clear_op:
            skip = !sel_bit; // see RQ3
         skip_bit_set_op:
            skip = sel_bit;
         inc_skip_op, dec_skip_op:
         begin
            res = (op_q == inc_skip_op) ? inc_val : dec_val; // see RQ4
            wr_mem = 1'b1;
            skip = is_zero(res);
         end
         inc_skip_to_acc_op, dec_skip_to_acc_op:
         begin
            res = (op_q == inc_skip_to_acc_op) ? inc_val : dec_val; // see RQ5
            wr_acc = 1'b1;
            skip = is_zero(res);
         end
         table_read_current_page, table_read_last_page:
         begin
            res = pm_rdata[7:0]; // see RQ8
            wr_mem = 1'b1;
            two_base = 1'b1;
         end
         clear_mem_op:
         begin
            res = 8'h00; // see RQ17
            wr_mem = 1'b1;
         end
         set_mem_op:
         begin
            res = 8'hff;
            wr_mem = 1'b1;
         end
         nibble_exchange_op:
         begin
            res = swap_nib(dm_rdata); // see RQ10
            wr_mem = 1'b1;
         end
         nibble_exchange_to_acc_op:
         begin
            res = swap_nib(dm_rdata);
            wr_acc = 1'b1;
         end
         default:
            res = dm_rdata; // see RQ14
      endcase
   end

   assign pc_low_hit = wr_mem && (dm_addr == `BMIE_PC_LOW_ADDR); // see RQ7
   assign ncyc = (two_base ? 2'd2 : 2'd1) + {1'b0, skip} + {1'b0, pc_low_hit}; // see RQ6
   // the fetched follower is simply never executed, the added cycle idles
   assign pc_next_seq = pc + (skip ? 2'd2 : 2'd1); // see RQ18
   assign sp_dec = sp - 1'b1;
   assign stack_top = stack[sp_dec[$clog2(STACK_DEPTH)-1:0]];
   assign pre_pair = (op_q == watchdog_preclear_first && pre2_seen) ||
                     (op_q == watchdog_preclear_second && pre1_seen);
   assign wd_clear = commit && (op_q == watchdog_clear_op || pre_pair || op_q == halt_op);
   assign next_pc = (op_q == jump_op || op_q == call_op) ? target_q :
                    (op_q == subroutine_return_op || op_q == return_imm_op ||
                     op_q == interrupt_return_op) ? stack_top :
                    pc_low_hit ? {pc[PC_W-1:8], res} : pc_next_seq;

   assign seq_bus.start = commit && clk_en;
   assign seq_bus.ncyc = ncyc;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= bmie_idle;
      else if (clk_en)
      begin
         unique case (state)
            bmie_idle:
               if (instr_valid)
                  state <= bmie_exec;
            bmie_exec:
               state <= bmie_wait;
            bmie_wait:
               if (seq_bus.done)
                  state <= halt_pending ? bmie_halt : bmie_idle; // see RQ13
            bmie_halt:
               if (wake)
                  state <= bmie_idle;
         endcase
      end
   end

   // latch the instruction and present both memory addresses a clock early
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         op_q <= no_operation;
         bit_q <= 3'h0;
         imm_q <= 8'h00;
         target_q <= '0;
         dm_addr <= 8'h00;
         pm_addr <= '0;
      end
      else if (accept)
      begin
         op_q <= instr_op;
         bit_q <= instr_bit;
         imm_q <= instr_imm;
         target_q <= instr_target;
         dm_addr <= instr_addr;
         if (instr_op == table_read_last_page)
            pm_addr <= {{(PC_W-8){1'b1}}, tbl_ptr}; // see RQ9
         else
            pm_addr <= {pc[PC_W-1:8], tbl_ptr};
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pc <= '0;
         sp <= '0;
         accumulator <= `BMIE_RST_ACC;
         table_high_latch <= '0;
         dm_we <= 1'b0;
         dm_wdata <= 8'h00;
         skip_taken <= 1'b0;
         int_return <= 1'b0;
         halt_pending <= 1'b0;
      end
      else if (clk_en)
      begin
         dm_we <= commit && wr_mem;
         int_return <= commit && op_q == interrupt_return_op;
         if (seq_bus.done)
         begin
            skip_taken <= 1'b0;
            halt_pending <= 1'b0;
         end
         if (commit)
         begin
            pc <= next_pc;
            dm_wdata <= res;
            skip_taken <= skip;
            halt_pending <= op_q == halt_op;
            if (wr_acc)
               accumulator <= res;
            if (op_q == table_read_current_page || op_q == table_read_last_page)
               table_high_latch <= pm_hi;
            // a full stack holds its pointer and each further push overwrites entry 0
            if (op_q == call_op)
               sp <= (sp == SP_W'(STACK_DEPTH)) ? sp : sp + 1'b1; // see RQ16
            else if (next_pc == stack_top && op_q != jump_op && !pc_low_hit &&
                     (op_q == subroutine_return_op || op_q == return_imm_op ||
                      op_q == interrupt_return_op) && sp != '0)
               sp <= sp_dec;
         end
      end
   end

   logic [$clog2(STACK_DEPTH)-1:0] push_idx;
   assign push_idx = (sp == SP_W'(STACK_DEPTH)) ? '0 : sp[$clog2(STACK_DEPTH)-1:0];

   always_ff @(posedge core_clk)
   begin
      if (clk_en && commit && op_q == call_op)
         stack[push_idx] <= pc + 1'b1; // see RQ16
   end

   // watchdog flags; the timeout input wins over an instruction clearing it
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre1_seen <= 1'b0;
         pre2_seen <= 1'b0;
         timeout_flag <= 1'b0;
         power_down_flag <= 1'b0;
         watchdog_reset <= 1'b0;
      end
      else if (clk_en)
      begin
         watchdog_reset <= wd_clear; // see RQ11
         if (wd_clear)
         begin
            pre1_seen <= 1'b0;
            pre2_seen <= 1'b0;
            power_down_flag <= op_q == halt_op; // see RQ15
         end
         else if (commit && op_q == watchdog_preclear_first)
            pre1_seen <= 1'b1; // see RQ12
         else if (commit && op_q == watchdog_preclear_second)
            pre2_seen <= 1'b1;
         if (watchdog_timeout)
            timeout_flag <= 1'b1;
         else if (wd_clear)
            timeout_flag <= 1'b0;
      end
   end

   // events, mask and the register port
   logic [`BMIE_EV_W-1:0] ev_set;
   logic [`BMIE_EV_W-1:0] ev_w1c;
   logic [31:0] rd_mux;

   assign ev_set = {watchdog_timeout, wd_clear, commit && op_q == halt_op, commit && skip};
   assign ev_w1c = (reg_wr && reg_addr == `BMIE_REG_STATUS) ? reg_wdata[`BMIE_EV_W-1:0] : '0;
   assign irq = |(ev_status & ev_mask);
   assign rd_mux = (reg_addr == `BMIE_REG_STATUS) ? 32'(ev_status) :
                   (reg_addr == `BMIE_REG_MASK) ? 32'(ev_mask) :
                   (reg_addr == `BMIE_REG_STATE) ? 32'({sp, 5'h00, sys_clk_stop,
                                                       timeout_flag, power_down_flag}) :
                   (reg_addr == `BMIE_REG_ACC) ? 32'(accumulator) :
                   (reg_addr == `BMIE_REG_PC) ? 32'(pc) :
                   (reg_addr == `BMIE_REG_TABLE_HIGH) ? 32'(table_high_latch) : 32'h0;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ev_status <= '0;
         ev_mask <= `BMIE_RST_MASK;
         reg_rdata <= 32'h0;
      end
      else if (clk_en)
      begin
         ev_status <= (ev_status & ~ev_w1c) | ev_set;
         if (reg_wr && reg_addr == `BMIE_REG_MASK)
            ev_mask <= reg_wdata[`BMIE_EV_W-1:0];
         reg_rdata <= reg_rd ? rd_mux : 32'h0;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n || !clk_en);

   a_jump_two_cycles: assert property (accept && instr_op == jump_op |-> ##7 instr_done) // see RQ1
      else $error("jump did not end after eight clocks");
   a_skip_zero_len: assert property (commit && op_q == skip_zero_op && dm_rdata == 8'h00
      |-> !instr_done [*6] ##1 instr_done) // see RQ2
      else $error("taken zero skip wrong length");
   a_bit_skip_sel: assert property (commit && op_q == skip_bit_set_op
      |=> skip_taken == $past(sel_bit)) // see RQ3
      else $error("bit skip decision wrong");
   a_inc_write_back: assert property (commit && op_q == inc_skip_op
      |=> dm_we && dm_wdata == $past(inc_val)) // see RQ4
      else $error("increment skip write back wrong");
   a_acc_form_only: assert property (commit && op_q == dec_skip_to_acc_op
      |=> !dm_we && accumulator == $past(dec_val)) // see RQ5
      else $error("decrement to accumulator wrong");
   a_skip_adds_cycle: assert property (commit && op_q == skip_bit_clear_op && !sel_bit
      |-> ##6 instr_done) // see RQ6
      else $error("taken skip missing extra cycle");
   a_pc_low_penalty: assert property (commit && op_q == clear_mem_op && pc_low_hit
      |-> ##6 instr_done ##1 pc[7:0] == 8'h00) // see RQ7
      else $error("low pc write penalty wrong");
   a_table_high: assert property (commit && op_q == table_read_current_page
      |=> table_high_latch == $past(pm_hi) ##5 instr_done) // see RQ8
      else $error("table read high latch or length wrong");
   a_last_page_addr: assert property (commit && op_q == table_read_last_page
      |-> &pm_addr[PC_W-1:8]) // see RQ9
      else $error("last page read not on final page");
   a_swap_acc: assert property (commit && op_q == nibble_exchange_to_acc_op
      |=> accumulator == {$past(dm_rdata[3:0]), $past(dm_rdata[7:4])} ##1 instr_done) // see RQ10
      else $error("swap to accumulator wrong");
   a_watchdog_clear: assert property (commit && op_q == watchdog_clear_op && !watchdog_timeout
      |=> watchdog_reset && !power_down_flag && !timeout_flag) // see RQ11
      else $error("watchdog clear flags wrong");
   a_lone_preclear: assert property (commit && op_q == watchdog_preclear_first && !pre2_seen
      |=> !watchdog_reset && $stable(power_down_flag)) // see RQ12
      else $error("lone pre-clear changed flags");
   a_halt_enters: assert property (commit && op_q == halt_op
      |=> power_down_flag && watchdog_reset ##1 !sys_clk_stop ##1 sys_clk_stop) // see RQ13
      else $error("halt did not enter power-down");
   a_call_push: assert property (commit && op_q == call_op
      |=> pc == $past(target_q) && stack_top == $past(pc) + 1'b1) // see RQ16
      else $error("call push or target wrong");
endmodule

// [tb/bmie_mem_model.sv]
`timescale 1ns/1ps
module bmie_mem_model
(
   input wire logic core_clk,
   input wire logic [7:0] dm_addr,
   output logic [7:0] dm_rdata,
   input wire logic dm_we,
   input wire logic [7:0] dm_wdata,
   input wire logic [11:0] pm_addr,
   output logic [14:0] pm_rdata
);
   logic [7:0] mem [256];
   initial
   begin
      for (int i = 0; i < 256; i++) mem[i] = 8'h00;
   end
   assign dm_rdata = mem[dm_addr];
   // halves built from different address bits so a swapped or shifted fetch shows
   assign pm_rdata = {pm_addr[6:0] ^ 7'h2b, pm_addr[11:4]};
   always @(posedge core_clk)
      if (dm_we) mem[dm_addr] <= dm_wdata;
endmodule

// [tb/branch_misc_instruction_exec_tb.sv]
`timescale 1ns/1ps
module branch_misc_instruction_exec_tb;
   import bmie_pkg::*;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic clk_en = 1'b1;
   logic instr_valid = 1'b0;
   bmie_op_t instr_op = no_operation;
   logic [7:0] instr_addr = 8'h00;
   logic [2:0] instr_bit = 3'h0;
   logic [7:0] instr_imm = 8'h00;
   logic [11:0] instr_target = 12'h000;
   logic [7:0] tbl_ptr = 8'h00;
   logic watchdog_timeout = 1'b0;
   logic wake = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic instr_ready, instr_done, skip_taken, dm_we, timeout_flag, power_down_flag;
   logic watchdog_reset, sys_clk_stop, irq, int_ret;
   logic [7:0] dm_addr, dm_rdata, dm_wdata, accumulator, imm_v, ptr_v;
   logic [11:0] pm_addr, pc, p, a, tgt_v;
   logic [14:0] pm_rdata;
   logic [6:0] table_high_latch;
   logic [31:0] reg_rdata;
   logic [7:0] pat = 8'h5a;
   int miscompares = 0;
   int num_checks = 0;
   int wd_pulses = 0;
   int ir_pulses = 0;
   int w0, k;

   bmie_core i_bmie_core (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
      .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_op(instr_op),
      .instr_addr(instr_addr), .instr_bit(instr_bit), .instr_imm(instr_imm),
      .instr_target(instr_target), .tbl_ptr(tbl_ptr), .instr_done(instr_done),
      .skip_taken(skip_taken), .dm_addr(dm_addr), .dm_rdata(dm_rdata), .dm_we(dm_we),
      .dm_wdata(dm_wdata), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .pc(pc),
      .accumulator(accumulator), .table_high_latch(table_high_latch),
      .timeout_flag(timeout_flag), .power_down_flag(power_down_flag),
      .watchdog_reset(watchdog_reset), .sys_clk_stop(sys_clk_stop), .int_return(int_ret),
      .watchdog_timeout(watchdog_timeout), .wake(wake), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq(irq));
   bmie_mem_model i_bmie_mem_model (.core_clk(core_clk), .dm_addr(dm_addr),
      .dm_rdata(dm_rdata), .dm_we(dm_we), .dm_wdata(dm_wdata), .pm_addr(pm_addr),
      .pm_rdata(pm_rdata));

   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) if (watchdog_reset === 1'b1) wd_pulses++;
   always @(posedge core_clk) if (int_ret === 1'b1) ir_pulses++;

   function automatic logic [7:0] dm(input logic [7:0] ad);
      return i_bmie_mem_model.mem[ad];
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wait_ready;
      for (k = 0; k < 40 && instr_ready !== 1'b1; k++)
      begin
         @(posedge core_clk);
         #1;
      end
   endtask
   // counts edges from accept to the done pulse; done is seen just after edge 4n-2
   // and is sampled at edge 4n-1
   task automatic exec(input bmie_op_t op, input logic [7:0] ad, input logic [2:0] b,
                       input int n, input logic sk);
      wait_ready();
      @(posedge core_clk);
      instr_valid <= 1'b1;
      instr_op <= op;
      instr_addr <= ad;
      instr_bit <= b;
      instr_imm <= imm_v;
      instr_target <= tgt_v;
      tbl_ptr <= ptr_v;
      @(posedge core_clk);
      instr_valid <= 1'b0;
      for (k = 1; k < 20; k++)
      begin
         @(posedge core_clk);
         #1;
         if (instr_done === 1'b1) break;
      end
      check(k + 1, 4 * n - 1);
      check(skip_taken, sk);
   endtask
   task automatic reg_check(input logic [7:0] ad, input logic [31:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask
   task automatic reg_write(input logic [7:0] ad, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic pulse(input int which);
      @(posedge core_clk);
      if (which == 0) watchdog_timeout <= 1'b1;
      else wake <= 1'b1;
      @(posedge core_clk);
      watchdog_timeout <= 1'b0;
      wake <= 1'b0;
      #1;
   endtask

   initial
   begin
      #100000;
      miscompares++;
      tally_and_finish();
   end

   initial
   begin
      imm_v = 8'h00;
      ptr_v = 8'h00;
      tgt_v = 12'h000;
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      check({instr_ready, accumulator, timeout_flag, power_down_flag, irq}, 12'h800);
      exec(set_mem_op, 8'h20, 3'h0, 1, 1'b0);
      check(dm(8'h20), 8'hff);
      exec(clear_mem_op, 8'h21, 3'h0, 1, 1'b0);
      check(dm(8'h21), 8'h00);
      exec(skip_zero_op, 8'h21, 3'h0, 2, 1'b1);
      exec(skip_zero_op, 8'h20, 3'h0, 1, 1'b0);
      exec(skip_zero_copy_op, 8'h20, 3'h0, 1, 1'b0);
      check(accumulator, 8'hff);
      @(posedge core_clk);
      i_bmie_mem_model.mem[8'h23] <= pat;
      i_bmie_mem_model.mem[8'h22] <= 8'h01;
      for (int i = 0; i < 8; i++)
      begin
         exec(skip_bit_clear_op, 8'h23, i[2:0], 1 + !pat[i], !pat[i]);
         exec(skip_bit_set_op, 8'h23, i[2:0], 1 + pat[i], pat[i]);
      end
      exec(inc_skip_op, 8'h20, 3'h0, 2, 1'b1);
      check(dm(8'h20), 8'h00);
      exec(dec_skip_op, 8'h21, 3'h0, 1, 1'b0);
      check(dm(8'h21), 8'hff);
      exec(dec_skip_op, 8'h22, 3'h0, 2, 1'b1);
      check(dm(8'h22), 8'h00);
      exec(inc_skip_to_acc_op, 8'h21, 3'h0, 2, 1'b1);
      check({accumulator, dm(8'h21)}, 16'h00ff);
      exec(dec_skip_to_acc_op, 8'h23, 3'h0, 1, 1'b0);
      check({accumulator, dm(8'h23)}, 16'h595a);
      exec(clear_mem_op, 8'h06, 3'h0, 2, 1'b0);
      tgt_v = 12'h123;
      exec(jump_op, 8'h00, 3'h0, 2, 1'b0);
      check(pc, 12'h123);
      p = pc;
      tgt_v = 12'h200;
      exec(call_op, 8'h00, 3'h0, 2, 1'b0);
      check(pc, 12'h200);
      exec(subroutine_return_op, 8'h00, 3'h0, 2, 1'b0);
      check(pc, p + 12'h001);
      p = pc;
      ptr_v = 8'h3c;
      exec(table_read_current_page, 8'h24, 3'h0, 2, 1'b0);
      a = {p[11:8], 8'h3c};
      check({dm(8'h24), table_high_latch}, {a[11:4], a[6:0] ^ 7'h2b});
      exec(table_read_last_page, 8'h25, 3'h0, 2, 1'b0);
      a = {4'hf, 8'h3c};
      check({dm(8'h25), table_high_latch}, {a[11:4], a[6:0] ^ 7'h2b});
      imm_v = 8'h3c;
      p = pc;
      // every return is preceded by a call so it never pops an empty stack
      exec(call_op, 8'h00, 3'h0, 2, 1'b0);
      exec(return_imm_op, 8'h00, 3'h0, 2, 1'b0);
      check({accumulator, pc}, {8'h3c, p + 12'h001});
      exec(call_op, 8'h00, 3'h0, 2, 1'b0);
      exec(interrupt_return_op, 8'h00, 3'h0, 2, 1'b0);
      check({timeout_flag, power_down_flag}, 2'b00);
      check(ir_pulses, 1);
      exec(nibble_exchange_op, 8'h23, 3'h0, 1, 1'b0);
      check(dm(8'h23), 8'ha5);
      exec(nibble_exchange_to_acc_op, 8'h23, 3'h0, 1, 1'b0);
      check({accumulator, dm(8'h23)}, 16'h5aa5);
      exec(no_operation, 8'h23, 3'h0, 1, 1'b0);
      check({accumulator, dm(8'h23)}, 16'h5aa5);
      pulse(0);
      check(timeout_flag, 1'b1);
      w0 = wd_pulses;
      exec(watchdog_clear_op, 8'h00, 3'h0, 1, 1'b0);
      check({timeout_flag, power_down_flag, wd_pulses > w0}, 3'b001);
      pulse(0);
      exec(watchdog_preclear_first, 8'h00, 3'h0, 1, 1'b0);
      check(timeout_flag, 1'b1);
      exec(watchdog_preclear_second, 8'h00, 3'h0, 1, 1'b0);
      check(timeout_flag, 1'b0);
      pulse(0);
      exec(halt_op, 8'h00, 3'h0, 1, 1'b0);
      @(posedge core_clk);
      #1;
      check({sys_clk_stop, instr_ready, power_down_flag, timeout_flag}, 4'ha);
      check(dm(8'h23), 8'ha5);
      pulse(1);
      wait_ready();
      check({instr_ready, sys_clk_stop}, 2'b10);
      // a timeout pulse while the clock enable is low must not reach the flag
      @(posedge core_clk);
      clk_en <= 1'b0;
      pulse(0);
      @(posedge core_clk);
      clk_en <= 1'b1;
      #1;
      check(timeout_flag, 1'b0);
      reg_check(8'h0c, 32'h0000005a);
      reg_check(8'h00, 32'h0000000f);
      check(irq, 1'b0);
      reg_write(8'h04, 32'h00000002);
      check(irq, 1'b1);
      reg_write(8'h00, 32'h0000000f);
      check(irq, 1'b0);
      reg_check(8'h00, 32'h00000000);
      reg_check(8'h40, 32'h00000000);
      tally_and_finish();
   end
endmodule
